/* File: include/acf_pkg.sv */
// Purpose: constants shared by the serial command and frame logic
// Assumes: master clock of 20 MHz drives the whole block
// Notes: register indices are serial-side addresses, offsets are bus bytes
`default_nettype none
package acf_pkg;
    // command words
    localparam logic [15:0] CMD_NULL = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0011;
    localparam logic [15:0] CMD_STANDBY = 16'h0022;
    localparam logic [15:0] CMD_WAKE = 16'h0033;
    localparam logic [15:0] CMD_LOCK = 16'h0555;
    localparam logic [15:0] CMD_UNLOCK = 16'h0655;
    localparam logic [2:0] OP_READ = 3'h5;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_READ_ACK = 3'h7;
    localparam logic [2:0] OP_WRITE_ACK = 3'h2;
    localparam logic [15:0] RESP_RESET_OK = 16'hff42;
    // check words
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    localparam logic [15:0] POLY_ANSI = 16'h8005;
    localparam logic [15:0] CRC_SEED = 16'hffff;
    // word length field codes
    localparam logic [1:0] WL_16 = 2'h0;
    localparam logic [1:0] WL_24 = 2'h1;
    localparam logic [1:0] WL_32_ZERO = 2'h2;
    localparam logic [1:0] WL_32_SIGN = 2'h3;
    // frame shape
    localparam logic [7:0] FULL_FRAME_WORDS = 8'h04;
    localparam logic [7:0] STD_CRC_WORD = 8'h03;
    // timeout, counted in master clock cycles
    localparam int TIMEOUT_MCLK = 32768;
    localparam int TIMEOUT_COUNT = TIMEOUT_MCLK;
    // serial register indices
    localparam logic [5:0] REG_ID = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h01;
    localparam logic [5:0] REG_MODE = 6'h02;
    localparam logic [5:0] REG_CHAN = 6'h03;
    // bus byte offsets
    localparam logic [3:0] OFS_ID = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_MODE = 4'h8;
    localparam logic [3:0] OFS_CHAN = 4'hc;
    // mode register fields
    localparam int MODE_RX_CRC_BIT = 0;
    localparam int MODE_CRC_TYPE_BIT = 1;
    localparam int MODE_TIMEOUT_BIT = 2;
    localparam int MODE_WL_LSB = 3;
    localparam logic [15:0] MODE_RST = 16'h0008;
    localparam logic [15:0] CHAN_RST = 16'h0003;
    // status register fields
    localparam int STAT_LOCK_BIT = 15;
    localparam int STAT_CRC_ERR_BIT = 12;
endpackage
`default_nettype wire

/* File: rtl/acf_frame_logic.sv */
// Purpose: serial command decoder and frame engine of a two-channel converter
// Assumes: serial pins are asynchronous to i_clk and sampled by it
// Notes: serial clock must be well below a quarter of i_clk
//
// Operation
// - with channels off, host may send command-only frames; device accepts
// - 16-bit check words cover every frame bit before them, padding included
// - receive check enable bit in mode register, off after reset
// - on input check mismatch commands are dropped, register writes still land
// - any mismatch sets check error flag and next response is status
// - check error flag clears when status is shifted out
// - output check word always ends the output frame
// - check type bit picks polynomial 0x1021 or 0x8005 for both ways
// - every check word starts from seed all ones
// - with timeout enabled, frame longer than 32768 master clocks resets logic
// - after timeout the next serial clock starts a new frame
// - conversion words are 24-bit, truncated, padded or sign extended per length
// - conversion codes saturate at 0x7fffff and 0x800000
// - status holds per-channel new data flags, returned for no-op
// - unknown commands answer like the no-op
// - standby and wake commands are echoed in the next frame
// - lock limits commands to no-op, read, unlock; both are echoed
// - single read returns data; multi read returns 111-headed word then data
// - write answer is 010-headed with registers written minus one
// - reset latched at frame end, answers 0xff42 or 0x0011 if incomplete
// - standard frame: command, check, two zeros in; response, two data, check out
// - 16-bit words are left aligned, zero padded below
`default_nettype none
module acf_frame_logic #(
    parameter int TIMEOUT_CYCLES = acf_pkg::TIMEOUT_COUNT,
    parameter int CODE_IN_W = 26,
    parameter logic [15:0] ID_VALUE = 16'h5a01 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_data_ready_pin_n,
    output logic o_standby,
    input wire logic i_conv_valid,
    input wire logic signed [CODE_IN_W-1:0] i_ch0_code,
    input wire logic signed [CODE_IN_W-1:0] i_ch1_code,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat
);
    typedef struct packed {
        logic sclk_m, sclk_s, sclk_p;
        logic cs_m, cs_s, cs_p;
        logic din_m, din_s;
        logic active;
        logic [1:0] wl;
        logic [4:0] bitcnt;
        logic [7:0] wcnt;
        logic [31:0] in_sh;
        logic [15:0] in_crc;
        logic [15:0] out_crc;
        logic crc_seen;
        logic crc_match;
        logic [15:0] cmd;
        logic [6:0] wr_cnt;
        logic [15:0] resp;
        logic resp_stat;
        logic rd_multi;
        logic [5:0] rd_addr;
        logic [6:0] rd_n;
        logic [15:0] mode;
        logic [15:0] chan;
        logic lock;
        logic standby;
        logic crc_err;
        logic [1:0] nd;
        logic [23:0] code0;
        logic [23:0] code1;
        logic [15:0] tmo;
        logic dout;
        logic oe;
        logic data_ready_pin_n;
        logic ack;
        logic [31:0] wbdat;
    } acf_state_t;

    acf_state_t q;
    acf_state_t d;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b,
                                             input logic [15:0] p);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
    endfunction

    function automatic logic [4:0] last_bit(input logic [1:0] wl);
        return (wl == acf_pkg::WL_16) ? 5'h0f :
               (wl == acf_pkg::WL_24) ? 5'h17 : 5'h1f;
    endfunction

    // word ends with its last bit in bit 0; pick the 16 leading bits
    function automatic logic [15:0] top16(input logic [31:0] v,
                                          input logic [1:0] wl);
        return (wl == acf_pkg::WL_16) ? v[15:0] :
               (wl == acf_pkg::WL_24) ? v[23:8] : v[31:16];
    endfunction

    function automatic logic [31:0] fmt(input logic [23:0] c,
                                        input logic [1:0] wl);
        if (wl == acf_pkg::WL_16)
        begin
            return {c[23:8], 16'h0000};
        end
        if (wl == acf_pkg::WL_32_SIGN)
        begin
            return {{8{c[23]}}, c};
        end
        return {c, 8'h00};
    endfunction

    function automatic logic [23:0] sat(input logic signed [CODE_IN_W-1:0] x);
        if (x > CODE_IN_W'(24'sh7fffff))
        begin
            return 24'h7fffff;
        end
        if (x < -CODE_IN_W'(25'sh800000))
        begin
            return 24'h800000;
        end
        return x[23:0];
    endfunction

    function automatic logic [15:0] reg_rd(input logic [5:0] a,
                                           input logic [15:0] stat,
                                           input logic [15:0] mode,
                                           input logic [15:0] chan);
        case (a)
            acf_pkg::REG_ID: return ID_VALUE;
            acf_pkg::REG_STATUS: return stat;
            acf_pkg::REG_MODE: return mode;
            acf_pkg::REG_CHAN: return chan;
            default: return 16'h0000;
        endcase
    endfunction

    logic sclk_rise, sclk_fall, cs_rise;
    logic [15:0] stat, poly, resp16;
    logic [1:0] mode_wl;
    logic [7:0] eff_w, ocrc_idx, icrc_idx;
    logic [4:0] eff_b;
    logic [1:0] eff_wl;
    logic [31:0] ow;
    logic obit;
    logic is_write;

    assign sclk_rise = q.sclk_s & ~q.sclk_p;
    assign sclk_fall = ~q.sclk_s & q.sclk_p;
    assign cs_rise = q.cs_s & ~q.cs_p;
    assign mode_wl = q.mode[acf_pkg::MODE_WL_LSB +: 2];
    assign poly = q.mode[acf_pkg::MODE_CRC_TYPE_BIT] ? acf_pkg::POLY_ANSI
                                                     : acf_pkg::POLY_CCITT;
    assign eff_w = q.active ? q.wcnt : 8'h00;
    assign eff_b = q.active ? q.bitcnt : 5'h00;
    assign eff_wl = q.active ? q.wl : mode_wl;
    assign is_write = (q.cmd[15:13] == acf_pkg::OP_WRITE);
    assign ocrc_idx = q.rd_multi ? 8'({1'b0, q.rd_n} + 8'h02)
                                 : acf_pkg::STD_CRC_WORD;
    assign icrc_idx = is_write ? 8'({1'b0, q.cmd[6:0]} + 8'h02) : 8'h01;

    always_comb
    begin
        stat = 16'h0000;
        stat[acf_pkg::STAT_LOCK_BIT] = q.lock;
        stat[acf_pkg::STAT_CRC_ERR_BIT] = q.crc_err;
        stat[1:0] = q.nd;
    end

    assign resp16 = q.resp_stat ? stat : q.resp;

    // output word selected by word index, left aligned in 32 bits
    always_comb
    begin
        ow = 32'h0;
        if (eff_w == 8'h00)
        begin
            ow = {resp16, 16'h0000};
        end
        else if (eff_w == ocrc_idx)
        begin
            ow = {q.out_crc, 16'h0000};
        end
        else if (q.rd_multi)
        begin
            if (eff_w <= 8'({1'b0, q.rd_n} + 8'h01))
            begin
                ow = {reg_rd(6'(q.rd_addr + eff_w[5:0] - 6'h01), stat,
                             q.mode, q.chan), 16'h0000};
            end
        end
        else if (eff_w == 8'h01)
        begin
            ow = fmt(q.code0, eff_wl);
        end
        else if (eff_w == 8'h02)
        begin
            ow = fmt(q.code1, eff_wl);
        end
        obit = ow[5'h1f - eff_b];
    end

    always_comb
    begin
        logic [31:0] word;
        logic [15:0] w16;
        logic [5:0] wa;
        word = {q.in_sh[30:0], q.din_s};
        w16 = top16(word, q.wl);
        wa = 6'(q.cmd[12:7] + q.wcnt[5:0] - 6'h01);
        d = q;
        d.sclk_m = i_sclk;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.cs_m = i_cs_n;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.din_m = i_din;
        d.din_s = q.din_m;
        d.oe = ~q.cs_s;
        d.ack = i_wb_cyc & i_wb_stb & ~q.ack;

        // register bus: one wait cycle, unmapped reads give zero
        if (i_wb_cyc & i_wb_stb & ~q.ack)
        begin
            case (i_wb_adr)
                acf_pkg::OFS_ID: d.wbdat = {16'h0000, ID_VALUE};
                acf_pkg::OFS_STATUS: d.wbdat = {16'h0000, stat};
                acf_pkg::OFS_MODE: d.wbdat = {16'h0000, q.mode};
                acf_pkg::OFS_CHAN: d.wbdat = {16'h0000, q.chan};
                default: d.wbdat = 32'h0;
            endcase
            if (i_wb_we & (i_wb_adr == acf_pkg::OFS_MODE))
            begin
                if (i_wb_sel[0])
                    d.mode[7:0] = i_wb_dat[7:0];
                if (i_wb_sel[1])
                    d.mode[15:8] = i_wb_dat[15:8];
            end
            if (i_wb_we & (i_wb_adr == acf_pkg::OFS_CHAN))
            begin
                if (i_wb_sel[0])
                    d.chan[7:0] = i_wb_dat[7:0];
                if (i_wb_sel[1])
                    d.chan[15:8] = i_wb_dat[15:8];
            end
        end

        if (q.active)
        begin
            d.tmo = 16'(q.tmo + 16'h0001);
        end

        // launch side: a rising edge with no frame open starts one
        if (sclk_rise & ~q.cs_s)
        begin
            if (~q.active)
            begin
                d.active = 1'b1;
                d.wl = mode_wl;
                d.bitcnt = 5'h00;
                d.wcnt = 8'h00;
                d.in_crc = acf_pkg::CRC_SEED;
                d.out_crc = acf_pkg::CRC_SEED;
                d.crc_seen = 1'b0;
                d.crc_match = 1'b0;
                d.cmd = acf_pkg::CMD_NULL;
                d.wr_cnt = 7'h00;
                d.tmo = 16'h0000;
            end
            d.dout = obit;
            if (eff_w < ocrc_idx)
            begin
                d.out_crc = crc_step(q.active ? q.out_crc : acf_pkg::CRC_SEED,
                                     obit, poly);
            end
        end

        // capture side
        if (sclk_fall & ~q.cs_s & q.active)
        begin
            d.in_sh = word;
            if (q.wcnt < icrc_idx)
            begin
                d.in_crc = crc_step(q.in_crc, q.din_s, poly);
            end
            if (q.bitcnt == last_bit(q.wl))
            begin
                d.bitcnt = 5'h00;
                if (q.wcnt != 8'hff)
                    d.wcnt = 8'(q.wcnt + 8'h01);
                if (q.wcnt == 8'h00)
                begin
                    d.cmd = w16;
                    if (q.resp_stat)
                        d.crc_err = 1'b0;
                end
                // writes land as shifted, even if the check later fails
                if (is_write & ~q.lock & (q.wcnt != 8'h00) &
                    (q.wcnt <= 8'({1'b0, q.cmd[6:0]} + 8'h01)))
                begin
                    if (wa == acf_pkg::REG_MODE)
                    begin
                        d.mode = w16;
                        d.wr_cnt = 7'(q.wr_cnt + 7'h01);
                    end
                    else if (wa == acf_pkg::REG_CHAN)
                    begin
                        d.chan = w16;
                        d.wr_cnt = 7'(q.wr_cnt + 7'h01);
                    end
                end
                if (q.wcnt == icrc_idx)
                begin
                    d.crc_seen = 1'b1;
                    d.crc_match = (w16 == q.in_crc);
                end
                if (~q.rd_multi & (q.wcnt == 8'h02))
                    d.nd = 2'b00;
            end
            else
            begin
                d.bitcnt = 5'(q.bitcnt + 5'h01);
            end
        end

        if (q.cs_s)
        begin
            d.active = 1'b0;
        end

        // commands take effect when the frame closes
        if (cs_rise & q.active & (q.wcnt != 8'h00))
        begin
            d.resp_stat = 1'b0;
            d.rd_multi = 1'b0;
            if (q.mode[acf_pkg::MODE_RX_CRC_BIT] &
                ~(q.crc_seen & q.crc_match))
            begin
                d.crc_err = 1'b1;
                d.resp_stat = 1'b1;
            end
            else if (is_write)
            begin
                d.resp = {acf_pkg::OP_WRITE_ACK, q.cmd[12:7],
                          7'(q.wr_cnt - 7'h01)};
            end
            else if (q.cmd[15:13] == acf_pkg::OP_READ)
            begin
                if (q.cmd[6:0] == 7'h00)
                begin
                    d.resp = reg_rd(q.cmd[12:7], stat, q.mode, q.chan);
                end
                else
                begin
                    d.resp = {acf_pkg::OP_READ_ACK, q.cmd[12:0]};
                    d.rd_multi = 1'b1;
                    d.rd_addr = q.cmd[12:7];
                    d.rd_n = q.cmd[6:0];
                end
            end
            else if (q.cmd == acf_pkg::CMD_UNLOCK)
            begin
                d.lock = 1'b0;
                d.resp = q.cmd;
            end
            else if (q.lock)
            begin
                d.resp_stat = 1'b1;
            end
            else if (q.cmd == acf_pkg::CMD_LOCK)
            begin
                d.lock = 1'b1;
                d.resp = q.cmd;
            end
            else if ((q.cmd == acf_pkg::CMD_STANDBY) |
                     (q.cmd == acf_pkg::CMD_WAKE))
            begin
                d.standby = (q.cmd == acf_pkg::CMD_STANDBY);
                d.resp = q.cmd;
            end
            else if (q.cmd == acf_pkg::CMD_RESET)
            begin
                d.resp = q.cmd;
                if (q.wcnt >= acf_pkg::FULL_FRAME_WORDS)
                begin
                    d.resp = acf_pkg::RESP_RESET_OK;
                    d.mode = acf_pkg::MODE_RST;
                    d.chan = acf_pkg::CHAN_RST;
                    d.lock = 1'b0;
                    d.standby = 1'b0;
                    d.crc_err = 1'b0;
                    d.nd = 2'b00;
                end
            end
            else
            begin
                d.resp_stat = 1'b1;
            end
        end

        // new samples win over a same-cycle read clear
        if (i_conv_valid)
        begin
            if (d.chan[0])
            begin
                d.code0 = sat(i_ch0_code);
                d.nd[0] = 1'b1;
            end
            if (d.chan[1])
            begin
                d.code1 = sat(i_ch1_code);
                d.nd[1] = 1'b1;
            end
        end

        // a stalled frame is dropped without running its command
        if (q.active & q.mode[acf_pkg::MODE_TIMEOUT_BIT] &
            (q.tmo == 16'(TIMEOUT_CYCLES - 1)))
        begin
            d.active = 1'b0;
        end
        d.data_ready_pin_n = ~(|d.nd);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            q <= '0;
            q.sclk_m <= 1'b0;
            q.cs_m <= 1'b1;
            q.cs_s <= 1'b1;
            q.cs_p <= 1'b1;
            q.mode <= acf_pkg::MODE_RST;
            q.chan <= acf_pkg::CHAN_RST;
            q.resp_stat <= 1'b1;
            q.out_crc <= acf_pkg::CRC_SEED;
            q.in_crc <= acf_pkg::CRC_SEED;
            q.wl <= acf_pkg::WL_24;
            q.data_ready_pin_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_dout = q.dout;
    assign o_dout_oe = q.oe;
    assign o_data_ready_pin_n = q.data_ready_pin_n;
    assign o_standby = q.standby;
    assign o_wb_ack = q.ack;
    assign o_wb_dat = q.wbdat;
endmodule
`default_nettype wire

/* File: sim/acf_frame_logic_sva.sv */
// Purpose: port-level properties of the serial command and frame logic
// Assumes: one i_clk domain, i_reset synchronous and active high
// Notes: bus and pin outputs are registered, figures follow from that
`default_nettype none
module acf_frame_logic_chk (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_conv_valid,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_dout_oe,
    input wire logic o_data_ready_pin_n,
    input wire logic o_wb_ack,
    input wire logic [31:0] o_wb_dat
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    sequence s_bus_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    // four cycles covers the two-stage sync plus the output register
    sequence s_cs_low;
        !i_cs_n [*4];
    endsequence
    sequence s_cs_high;
        i_cs_n [*4];
    endsequence
    a_ack_answers: assert property (s_bus_req |=> o_wb_ack)
        else $error("bus request not acknowledged next cycle");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_no_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("ack without a request");
    a_rdata_hold: assert property
        ($changed(o_wb_dat) |-> o_wb_ack || $past(i_reset))
        else $error("read data moved outside an ack");
    a_oe_selected: assert property (s_cs_low |=> o_dout_oe)
        else $error("output not driven while selected");
    a_oe_released: assert property (s_cs_high |=> !o_dout_oe)
        else $error("output driven while deselected");
    a_data_ready_pin_new_data: assert property
        ($fell(o_data_ready_pin_n) |-> $past(i_conv_valid)
            || $past(i_conv_valid, 2))
        else $error("ready pin fell without new data");
    a_data_ready_pin_cleared: assert property
        ($rose(o_data_ready_pin_n) |-> $past(o_dout_oe)
            || $past(o_dout_oe, 2) || $past(i_reset))
        else $error("ready pin rose outside a frame");
endmodule
bind acf_frame_logic acf_frame_logic_chk u_chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_cs_n(i_cs_n),
    .i_conv_valid(i_conv_valid),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .o_dout_oe(o_dout_oe),
    .o_data_ready_pin_n(o_data_ready_pin_n),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat)
);
`default_nettype wire

/* File: sim/acf_frame_logic_test.sv */
// Purpose: self-checking bench for the serial command and frame logic
// Assumes: 20 MHz clock, host model clocks 24-bit words
// Notes: timeout shortened to 1024 cycles so a whole frame still fits
`default_nettype none
`define CHK(a, b) \
    begin \
        n_tests++; \
        if ((a) !== (b)) \
        begin \
            num_errors++; \
            $display("ERROR at %0t: got %h expected %h", $time, a, b); \
        end \
    end
module acf_frame_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ID = 16'h1234; // arbitrary value
    logic i_clk, i_reset = 1'b1, conv = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, ack, dout, oe, data_ready_pin_n, standby;
    logic signed [25:0] ch0 = '0, ch1 = '0;
    logic [3:0] adr = 4'h0;
    logic [3:0] lanes = 4'h3;
    logic [31:0] wdat = '0, rdat;
    logic [95:0] rsp;
    logic [15:0] q;
    logic [15:0] cp = acf_pkg::POLY_CCITT;
    logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    logic [15:0] rv [5] = '{ID, 16'h0, acf_pkg::MODE_RST, acf_pkg::CHAN_RST,
                            16'h0};
    int num_errors = 0;
    int n_tests = 0;
    wire sclk, cs_n, din, miso;
    // undriven line shows the inverse so a late or early sample shows up
    assign miso = oe ? dout : ~dout;
    acf_frame_logic #(.TIMEOUT_CYCLES(1024), .ID_VALUE(ID))
    DUT (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_sclk(sclk),
        .i_cs_n(cs_n),
        .i_din(din),
        .o_dout(dout),
        .o_dout_oe(oe),
        .o_data_ready_pin_n(data_ready_pin_n),
        .o_standby(standby),
        .i_conv_valid(conv),
        .i_ch0_code(ch0),
        .i_ch1_code(ch1),
        .i_wb_cyc(cyc),
        .i_wb_stb(stb),
        .i_wb_we(we),
        .i_wb_adr(adr),
        .i_wb_sel(lanes),
        .i_wb_dat(wdat),
        .o_wb_ack(ack),
        .o_wb_dat(rdat)
    );
    acf_host_model host (
        .i_clk(i_clk),
        .i_miso(miso),
        .o_sclk(sclk),
        .o_cs_n(cs_n),
        .o_din(din)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    function automatic logic [15:0] crc(input logic [71:0] d, input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 71; i > 71 - n; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? cp : 16'h0000);
        return c;
    endfunction
    task automatic wbx(input logic w, input logic [3:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            num_errors++;
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic fr(input logic [15:0] c, input logic [15:0] w, input int n);
        host.sel(1'b0);
        host.shift({c, 8'h00, w, 56'h0} >> (96 - n), n, rsp);
        host.sel(1'b1);
        rsp = rsp << (96 - n);
    endtask
    task automatic fc(input logic [15:0] c, input logic [15:0] w,
                      input logic [15:0] e);
        fr(c, w, 96);
        `CHK(rsp[95:80], e)
        `CHK(rsp[23:8], crc(rsp[95:24], 72))
    endtask
    task automatic close_out();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge i_clk);
        num_errors++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        wbx(1'b1, acf_pkg::OFS_ID, 16'hffff);
        for (int i = 0; i < 5; i++)
        begin
            wbx(1'b0, ra[i], 16'h0);
            `CHK(q, rv[i])
        end
        // upper lane only: the low byte must keep both channels enabled
        lanes <= 4'h2;
        wbx(1'b1, acf_pkg::OFS_CHAN, 16'h5aff);
        lanes <= 4'h3;
        wbx(1'b0, acf_pkg::OFS_CHAN, 16'h0);
        `CHK(q, 16'h5a03)
        ch0 <= 26'sh0800000;
        ch1 <= -26'sh0800001;
        conv <= 1'b1;
        @(posedge i_clk);
        conv <= 1'b0;
        repeat (4) @(posedge i_clk);
        `CHK(data_ready_pin_n, 1'b0)
        fc(acf_pkg::CMD_STANDBY, 16'h0, 16'h0003);
        `CHK(rsp[71:24], 48'h7fffff800000)
        `CHK({data_ready_pin_n, standby}, 2'b11)
        fc(acf_pkg::CMD_WAKE, 16'h0, acf_pkg::CMD_STANDBY);
        `CHK(standby, 1'b0)
        fc(acf_pkg::CMD_LOCK, 16'h0, acf_pkg::CMD_WAKE);
        fc(acf_pkg::CMD_STANDBY, 16'h0, acf_pkg::CMD_LOCK);
        `CHK(standby, 1'b0)
        fc(acf_pkg::CMD_UNLOCK, 16'h0, 16'h8000);
        fc(16'ha100, 16'h0, acf_pkg::CMD_UNLOCK);
        fc(16'h6180, 16'h0, acf_pkg::MODE_RST);
        fc(16'ha001, 16'h0, 16'h4180);
        fc(16'h0123, 16'h0, 16'he001);
        `CHK(rsp[71:24], {ID, 32'h0})
        wbx(1'b1, acf_pkg::OFS_MODE, 16'h000a);
        cp = acf_pkg::POLY_ANSI;
        fc(acf_pkg::CMD_NULL, 16'h0, 16'h0000);
        wbx(1'b1, acf_pkg::OFS_MODE, 16'h0009);
        cp = acf_pkg::POLY_CCITT;
        fc(acf_pkg::CMD_STANDBY, 16'h0, 16'h0000);
        `CHK(standby, 1'b0)
        fc(acf_pkg::CMD_NULL, crc(72'h0, 24), 16'h1000);
        fc(acf_pkg::CMD_NULL, crc(72'h0, 24), 16'h0000);
        wbx(1'b1, acf_pkg::OFS_MODE, 16'h000a);
        cp = acf_pkg::POLY_ANSI;
        fr(acf_pkg::CMD_RESET, 16'h0, 24);
        `CHK(rsp[95:80], 16'h0000)
        fc(acf_pkg::CMD_RESET, 16'h0, acf_pkg::CMD_RESET);
        cp = acf_pkg::POLY_CCITT;
        repeat (100) @(posedge i_clk);
        fc(acf_pkg::CMD_NULL, 16'h0, acf_pkg::RESP_RESET_OK);
        wbx(1'b0, acf_pkg::OFS_MODE, 16'h0);
        `CHK(q, acf_pkg::MODE_RST)
        wbx(1'b1, acf_pkg::OFS_MODE, 16'h000c);
        host.sel(1'b0);
        host.shift(96'hff, 8, rsp);
        repeat (1100) @(posedge i_clk);
        host.shift({acf_pkg::CMD_STANDBY, 80'h0}, 96, rsp);
        host.sel(1'b1);
        `CHK(standby, 1'b1)
        `CHK(rsp[95:80], 16'h0000)
        close_out();
    end
endmodule
`default_nettype wire

/* File: sim/acf_host_model.sv */
// Purpose: host end of the serial link, one bit every 400 ns
// Assumes: tasks are entered right after a rising edge of i_clk
// Notes: serial clock idles low outside frames
`default_nettype none
module acf_host_model (
    input wire logic i_clk,
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    // a stale data level is never left on the line between frames
    task automatic sel(input logic v);
        o_cs_n <= v;
        if (v)
            o_din <= ~o_din;
        repeat (8) @(posedge i_clk);
    endtask
    // launch on the rising edge, read late in the low phase
    task automatic shift(input logic [95:0] tx, input int n,
                         output logic [95:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_sclk <= 1'b1;
            o_din <= tx[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
            repeat (4) @(posedge i_clk);
            rx = {rx[94:0], i_miso};
        end
    endtask
endmodule
`default_nettype wire
